// >>> fam_pkg.sv
// Package for the flash array and security register map block.
// Assumes a single 25 MHz system clock domain.
package fam_pkg;
  localparam int unsigned ADDR_W        = 24;
  localparam int unsigned ARRAY_W       = 19;
  localparam logic [18:0] BYTES_4M_LAST = 19'h7ffff;
  localparam logic [18:0] BYTES_2M_LAST = 19'h3ffff;
  localparam int unsigned PAGE_LSB      = 8;
  localparam int unsigned SECTOR_LSB    = 12;
  localparam int unsigned BLOCK_LSB     = 16;
  localparam logic [7:0]  SFDP_OPCODE   = 8'h5a;
  localparam logic [7:0]  SIG_S         = 8'h53;
  localparam logic [7:0]  SIG_F         = 8'h46;
  localparam logic [7:0]  SIG_D         = 8'h44;
  localparam logic [7:0]  HDR_EXP_START = 8'h10;
  localparam logic [7:0]  BFPT_START    = 8'h30;
  localparam logic [7:0]  SFDP_LAST     = 8'h6f;
  localparam logic [7:0]  FILL_BYTE     = 8'hff;
  localparam logic [7:0]  ERASED_BYTE   = 8'hff;
  localparam logic [7:0]  BFPT_PTR      = 8'h30;
  localparam logic [1:0]  SREG_SFDP     = 2'h0;
  localparam logic [7:0]  SIG_S_OFS     = 8'h00;
  localparam logic [7:0]  SIG_F_OFS     = 8'h01;
  localparam logic [7:0]  SIG_D_OFS     = 8'h02;
  localparam logic [7:0]  BFPT_PTR_OFS  = 8'h0c;
  localparam logic [7:0]  HDR_PAD_BYTE  = 8'h00;
  localparam logic [3:0]  BLOCKS_4M     = 4'h8;
  localparam logic [3:0]  BLOCKS_2M     = 4'h4;

  typedef enum logic [2:0] {
    FAM_OP_READ  = 3'b000,
    FAM_OP_PROG  = 3'b001,
    FAM_OP_SECER = 3'b010,
    FAM_OP_BLKER = 3'b011,
    FAM_OP_CHIPER= 3'b100,
    FAM_OP_SRER  = 3'b101,
    FAM_OP_SRPRG = 3'b110,
    FAM_OP_SRLCK = 3'b111
  } fam_op_type;

  typedef struct packed {
    fam_op_type       op;
    logic [23:0]      addr;
    logic [7:0]       data;
    logic             sfdp;
  } fam_req_type;

  typedef struct packed {
    logic             ok;
    logic             rejected;
    logic [7:0]       data;
  } fam_rsp_type;
endpackage

// >>> fam_map.sv
// Address decode and access policy for main array and security registers.
// Assumes the command decoder issues one request per cycle on req_valid_in.
`timescale 1ns/100ps
module fam_map
  import fam_pkg::*;
#(
  parameter bit          IS_4M      = 1'b1,
  parameter logic [7:0]  BFPT_BYTE  = 8'h00
) (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  // Request
  input  wire logic        req_valid_in,
  input  wire fam_req_type req_in,
  // Storage port
  input  wire logic [7:0]  mem_rdata_in,
  output logic             mem_sreg_sel_out,
  output logic             mem_we_out,
  output logic [7:0]       mem_wdata_out,
  output logic             mem_erase_out,
  output logic [23:0]      mem_erase_base_out,
  output logic [23:0]      mem_erase_last_out,
  // Answer
  output logic             rsp_valid_out,
  output fam_rsp_type      rsp_out,
  output logic [3:0]       sreg_lock_out,
  output logic [3:0]       sector_span_out
);
  logic [3:0]  lock_r;
  logic [3:0]  lock_nxt;
  logic        in_array;
  logic        sr_hit;
  logic [1:0]  sr_idx;
  logic [7:0]  sfdp_byte;
  logic        accept;
  logic [23:0] a;
  logic [18:0] last;
  logic        rsp_v_r;
  fam_rsp_type rsp_r;
  logic        we_r;
  logic [7:0]  wd_r;
  logic        er_r;
  logic [23:0] eb_r;
  logic [23:0] el_r;

  assign a    = req_in.addr;
  assign last = IS_4M ? BYTES_4M_LAST : BYTES_2M_LAST;
  assign in_array = (a[23:ARRAY_W] == '0) && (a[18:0] <= last);
  assign sr_hit = (a[23:14] == '0) && (a[11:8] == '0);
  assign sr_idx = a[13:12];
  assign sector_span_out = IS_4M ? BLOCKS_4M : BLOCKS_2M;
  assign sreg_lock_out   = lock_r;
  // security registers kept apart from array
  assign mem_sreg_sel_out = !req_in.sfdp &&
                            (req_in.op inside {FAM_OP_SRER, FAM_OP_SRPRG, FAM_OP_SRLCK});

  always_comb begin
    sfdp_byte = FILL_BYTE;
    if (a[7:0] == SIG_S_OFS) sfdp_byte = SIG_S;
    else if (a[7:0] == SIG_F_OFS) sfdp_byte = SIG_F;
    else if (a[7:0] == SIG_D_OFS) sfdp_byte = SIG_D;
    else if (a[7:0] == BFPT_PTR_OFS) sfdp_byte = BFPT_PTR;
    else if (a[7:0] < HDR_EXP_START) sfdp_byte = HDR_PAD_BYTE;
    else if (a[7:0] >= BFPT_START && a[7:0] <= SFDP_LAST) sfdp_byte = BFPT_BYTE;
  end

  // Request legality
  always_comb begin
    accept   = 1'b0;
    lock_nxt = lock_r;
    if (req_in.sfdp) begin
      accept = (req_in.op == FAM_OP_READ);
    end else begin
      unique case (req_in.op)
        FAM_OP_READ, FAM_OP_PROG, FAM_OP_SECER, FAM_OP_BLKER:
          accept = in_array;
        FAM_OP_CHIPER:
          accept = 1'b1;
        FAM_OP_SRER, FAM_OP_SRPRG: begin
          accept = sr_hit && (sr_idx != SREG_SFDP) && !lock_r[sr_idx];
        end
        FAM_OP_SRLCK: begin
          accept = sr_hit && (sr_idx != SREG_SFDP);
          if (req_valid_in && accept) lock_nxt[sr_idx] = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) lock_r <= 4'h0;
    else lock_r <= lock_nxt;
  end

  // Storage strobes
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      we_r <= 1'b0;
      wd_r <= 8'h00;
      er_r <= 1'b0;
      eb_r <= 24'h000000;
      el_r <= 24'h000000;
    end else begin
      we_r <= req_valid_in && accept &&
              (req_in.op == FAM_OP_PROG || req_in.op == FAM_OP_SRPRG);
      wd_r <= mem_rdata_in & req_in.data;
      er_r <= req_valid_in && accept && !req_in.sfdp &&
              (req_in.op inside {FAM_OP_SECER, FAM_OP_BLKER, FAM_OP_CHIPER, FAM_OP_SRER});
      unique case (req_in.op)
        FAM_OP_SECER: begin
          eb_r <= {a[23:SECTOR_LSB], {SECTOR_LSB{1'b0}}};
          el_r <= {a[23:SECTOR_LSB], {SECTOR_LSB{1'b1}}};
        end
        FAM_OP_BLKER: begin
          eb_r <= {a[23:BLOCK_LSB], {BLOCK_LSB{1'b0}}};
          el_r <= {a[23:BLOCK_LSB], {BLOCK_LSB{1'b1}}};
        end
        FAM_OP_CHIPER: begin
          eb_r <= '0;
          el_r <= {{(ADDR_W - ARRAY_W){1'b0}}, last};
        end
        FAM_OP_SRER: begin
          eb_r <= {a[23:PAGE_LSB], {PAGE_LSB{1'b0}}};
          el_r <= {a[23:PAGE_LSB], {PAGE_LSB{1'b1}}};
        end
        default: begin
          eb_r <= eb_r;
          el_r <= el_r;
        end
      endcase
    end
  end

  // Answer
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rsp_v_r <= 1'b0;
      rsp_r   <= '0;
    end else begin
      rsp_v_r       <= req_valid_in;
      rsp_r.ok      <= accept;
      rsp_r.rejected<= !accept;
      rsp_r.data    <= req_in.sfdp ? sfdp_byte :
                       (accept && req_in.op == FAM_OP_READ) ? mem_rdata_in : ERASED_BYTE;
    end
  end

  assign mem_we_out         = we_r;
  assign mem_wdata_out      = wd_r;
  assign mem_erase_out      = er_r;
  assign mem_erase_base_out = eb_r;
  assign mem_erase_last_out = el_r;
  assign rsp_valid_out      = rsp_v_r;
  assign rsp_out            = rsp_r;

  property p_prog_clears;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      mem_we_out |-> ((mem_wdata_out & ~$past(mem_rdata_in)) == 8'h00);
  endproperty
  a_prog_clears: assert property (p_prog_clears) else $error("program set a bit");
  property p_sig;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (req_valid_in && req_in.sfdp && a[7:0] == SIG_F_OFS) |=> (rsp_out.data == SIG_F);
  endproperty
  a_sig: assert property (p_sig) else $error("signature byte wrong");
  property p_sfdp_ro;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (req_valid_in && req_in.sfdp && req_in.op != FAM_OP_READ) |=> (!mem_we_out && !mem_erase_out);
  endproperty
  a_sfdp_ro: assert property (p_sfdp_ro) else $error("parameter space written");
  property p_sr0;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (req_valid_in && sr_hit && sr_idx == SREG_SFDP &&
       req_in.op inside {FAM_OP_SRER, FAM_OP_SRPRG}) |=> rsp_out.rejected;
  endproperty
  a_sr0: assert property (p_sr0) else $error("register zero modified");
  property p_lock;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (req_valid_in && sr_hit && lock_r[sr_idx] && req_in.op == FAM_OP_SRPRG) |=> !mem_we_out;
  endproperty
  a_lock: assert property (p_lock) else $error("locked register written");
  property p_lock_sticky;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (lock_r != 4'h0) |=> ((lock_r & $past(lock_r)) == $past(lock_r));
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared");
  property p_sector;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (mem_erase_out && $past(req_in.op) == FAM_OP_SECER) |->
        (mem_erase_base_out[11:0] == 12'h000 && mem_erase_last_out[11:0] == 12'hfff);
  endproperty
  a_sector: assert property (p_sector) else $error("sector not aligned");
  property p_size;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (req_valid_in && !req_in.sfdp && req_in.op == FAM_OP_READ &&
       a > {{(ADDR_W - ARRAY_W){1'b0}}, last})
        |=> rsp_out.rejected;
  endproperty
  a_size: assert property (p_size) else $error("read beyond array");
  property p_fill;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (req_valid_in && req_in.sfdp && req_in.op == FAM_OP_READ && a[7:0] > SFDP_LAST)
        |=> (rsp_out.ok && rsp_out.data == FILL_BYTE);
  endproperty
  a_fill: assert property (p_fill) else $error("reserved byte not fixed");
  c_sfdp: cover property (@(posedge clk_sys_in) req_valid_in && req_in.sfdp);
  c_lock: cover property (@(posedge clk_sys_in) lock_r[1]);
  c_erase: cover property (@(posedge clk_sys_in) mem_erase_out);
endmodule // fam_map

// >>> fam_store_model.sv
// Byte storage model for the map block's storage port.
// Assumes one strobe per cycle; every byte starts erased.
`timescale 1ns/100ps
module fam_store_model
  import fam_pkg::*;
(
  // Clock
  input  wire logic        clk_sys_in,
  // Storage port
  input  wire logic [23:0] addr_in,
  input  wire logic        sreg_sel_in,
  input  wire logic        we_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        erase_in,
  input  wire logic [23:0] base_in,
  input  wire logic [23:0] last_in,
  output logic [7:0]       rdata_out
);
  logic [7:0]  mem [0:524287];
  logic [7:0]  sreg_mem [0:1023];
  logic [23:0] prev_addr_r;
  logic        prev_sel_r;

  initial begin
    foreach (mem[i]) mem[i] = ERASED_BYTE;
    foreach (sreg_mem[i]) sreg_mem[i] = ERASED_BYTE;
  end
  // Security registers live apart from the array
  assign rdata_out = sreg_sel_in ? sreg_mem[{addr_in[13:12], addr_in[7:0]}] :
                                   mem[addr_in[18:0]];

  // Write lands at the address taken one cycle earlier
  always @(posedge clk_sys_in) begin
    prev_addr_r <= addr_in;
    prev_sel_r  <= sreg_sel_in;
    if (we_in) begin
      if (prev_sel_r) sreg_mem[{prev_addr_r[13:12], prev_addr_r[7:0]}] <= wdata_in;
      else mem[prev_addr_r[18:0]] <= wdata_in;
    end
    if (erase_in) begin
      for (int i = int'(base_in); i <= int'(last_in); i++) begin
        if (prev_sel_r) sreg_mem[{i[13:12], i[7:0]}] <= ERASED_BYTE;
        else mem[i[18:0]] <= ERASED_BYTE;
      end
    end
  end
endmodule // fam_store_model

// >>> fam_map_test.sv
// Self-checking bench for the map block with a storage model.
// Assumes a 25 MHz clock and one-cycle registered answers.
`timescale 1ns/100ps
module fam_map_test;
  import fam_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        req_valid_in = 1'b0;
  fam_req_type req_in = '0;
  logic [7:0]  mem_rdata, mem_wdata;
  logic        mem_we, mem_erase, rsp_valid;
  logic [23:0] er_base, er_last, seen_base, seen_last;
  fam_rsp_type rsp;
  logic [3:0]  locks, span;
  logic        seen_we, seen_er;
  logic        mem_sreg_sel, seen_ok_2m;
  logic [7:0]  seen_wd;
  fam_rsp_type rsp_2m;
  logic [3:0]  span_2m;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #20 clk_sys_in = ~clk_sys_in;

  fam_map #(.IS_4M(1'b1), .BFPT_BYTE(8'h3c)) u_dut (.clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in), .req_valid_in(req_valid_in), .req_in(req_in),
    .mem_rdata_in(mem_rdata), .mem_we_out(mem_we), .mem_wdata_out(mem_wdata),
    .mem_erase_out(mem_erase), .mem_erase_base_out(er_base),
    .mem_erase_last_out(er_last), .rsp_valid_out(rsp_valid), .rsp_out(rsp),
    .sreg_lock_out(locks), .sector_span_out(span), .mem_sreg_sel_out(mem_sreg_sel));

  fam_store_model u_store (.clk_sys_in(clk_sys_in), .addr_in(req_in.addr),
    .sreg_sel_in(mem_sreg_sel),
    .we_in(mem_we), .wdata_in(mem_wdata), .erase_in(mem_erase),
    .base_in(er_base), .last_in(er_last), .rdata_out(mem_rdata));

  // Smaller variant watching the same requests
  fam_map #(.IS_4M(1'b0), .BFPT_BYTE(8'h3c)) u_dut_2m (.clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in), .req_valid_in(req_valid_in), .req_in(req_in),
    .mem_rdata_in(mem_rdata), .mem_sreg_sel_out(), .mem_we_out(), .mem_wdata_out(),
    .mem_erase_out(), .mem_erase_base_out(), .mem_erase_last_out(),
    .rsp_valid_out(), .rsp_out(rsp_2m), .sreg_lock_out(), .sector_span_out(span_2m));

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One request, answer judged 1 ns after the clock edge that takes it
  task automatic req(input fam_op_type op, input logic [23:0] a, input logic [7:0] d,
                     input logic sf, input logic ok, input logic [7:0] rd);
    @(posedge clk_sys_in) #1;
    req_in = '{op: op, addr: a, data: d, sfdp: sf};
    req_valid_in = 1'b1;
    @(posedge clk_sys_in) #1;
    req_valid_in = 1'b0;
    seen_we = mem_we;
    seen_er = mem_erase;
    seen_base = er_base;
    seen_last = er_last;
    seen_wd = mem_wdata;
    seen_ok_2m = rsp_2m.ok;
    chk("rsp_valid", 24'h1, {23'h0, rsp_valid});
    chk("rsp_ok", {23'h0, ok}, {23'h0, rsp.ok});
    chk("rsp_rejected", {23'h0, !ok}, {23'h0, rsp.rejected});
    if (op == FAM_OP_READ) chk("rsp_data", {16'h0, rd}, {16'h0, rsp.data});
    @(posedge clk_sys_in) #1;
  endtask

  task automatic t_sfdp;
    req(FAM_OP_READ, 24'h000000, 8'h00, 1'b1, 1'b1, SIG_S);
    req(FAM_OP_READ, 24'h000001, 8'h00, 1'b1, 1'b1, SIG_F);
    req(FAM_OP_READ, 24'h000002, 8'h00, 1'b1, 1'b1, SIG_D);
    req(FAM_OP_READ, 24'h00000c, 8'h00, 1'b1, 1'b1, BFPT_PTR);
    req(FAM_OP_READ, 24'h000010, 8'h00, 1'b1, 1'b1, FILL_BYTE);
    req(FAM_OP_READ, 24'h000030, 8'h00, 1'b1, 1'b1, 8'h3c);
    req(FAM_OP_READ, 24'h00006f, 8'h00, 1'b1, 1'b1, 8'h3c);
    req(FAM_OP_READ, 24'h000070, 8'h00, 1'b1, 1'b1, FILL_BYTE);
    req(FAM_OP_PROG, 24'h000030, 8'h00, 1'b1, 1'b0, 8'h00);
    chk("sfdp_we", 24'h0, {23'h0, seen_we});
    $display("test sfdp done");
  endtask

  task automatic t_prog;
    chk("span", 24'h8, {20'h0, span});
    req(FAM_OP_PROG, 24'h07ffff, 8'ha5, 1'b0, 1'b1, 8'h00);
    req(FAM_OP_PROG, 24'h07ffff, 8'h5f, 1'b0, 1'b1, 8'h00);
    req(FAM_OP_READ, 24'h07ffff, 8'h00, 1'b0, 1'b1, 8'h05);
    req(FAM_OP_PROG, 24'h080000, 8'h00, 1'b0, 1'b0, 8'h00);
    chk("oob_we", 24'h0, {23'h0, seen_we});
    req(FAM_OP_READ, 24'h080000, 8'h00, 1'b0, 1'b0, ERASED_BYTE);
    $display("test program done");
  endtask

  task automatic t_erase;
    req(FAM_OP_SECER, 24'h07f123, 8'h00, 1'b0, 1'b1, 8'h00);
    chk("sec_base", 24'h07f000, seen_base);
    chk("sec_last", 24'h07ffff, seen_last);
    req(FAM_OP_READ, 24'h07ffff, 8'h00, 1'b0, 1'b1, ERASED_BYTE);
    req(FAM_OP_BLKER, 24'h012345, 8'h00, 1'b0, 1'b1, 8'h00);
    chk("blk_base", 24'h010000, seen_base);
    chk("blk_last", 24'h01ffff, seen_last);
    req(FAM_OP_CHIPER, 24'h000000, 8'h00, 1'b0, 1'b1, 8'h00);
    chk("chip_erase", 24'h1, {23'h0, seen_er});
    $display("test erase done");
  endtask

  task automatic t_sreg;
    req(FAM_OP_SRPRG, 24'h000010, 8'h00, 1'b0, 1'b0, 8'h00);
    req(FAM_OP_SRER, 24'h000000, 8'h00, 1'b0, 1'b0, 8'h00);
    req(FAM_OP_SRLCK, 24'h000000, 8'h00, 1'b0, 1'b0, 8'h00);
    req(FAM_OP_SRPRG, 24'h001010, 8'h12, 1'b0, 1'b1, 8'h00);
    req(FAM_OP_SRPRG, 24'h001010, 8'hf0, 1'b0, 1'b1, 8'h00);
    chk("sreg_wdata", 24'h10, {16'h0, seen_wd});
    req(FAM_OP_READ, 24'h001010, 8'h00, 1'b0, 1'b1, ERASED_BYTE);
    req(FAM_OP_SRLCK, 24'h001000, 8'h00, 1'b0, 1'b1, 8'h00);
    chk("locks", 24'h2, {20'h0, locks});
    req(FAM_OP_SRPRG, 24'h0010ff, 8'h00, 1'b0, 1'b0, 8'h00);
    req(FAM_OP_SRER, 24'h001000, 8'h00, 1'b0, 1'b0, 8'h00);
    req(FAM_OP_SRPRG, 24'h0030ff, 8'h00, 1'b0, 1'b1, 8'h00);
    req(FAM_OP_SRER, 24'h002000, 8'h00, 1'b0, 1'b1, 8'h00);
    $display("test security registers done");
  endtask

  task automatic t_2m;
    chk("span_2m", 24'h4, {20'h0, span_2m});
    req(FAM_OP_READ, 24'h03ffff, 8'h00, 1'b0, 1'b1, ERASED_BYTE);
    chk("ok_2m_last", 24'h1, {23'h0, seen_ok_2m});
    req(FAM_OP_READ, 24'h040000, 8'h00, 1'b0, 1'b1, ERASED_BYTE);
    chk("ok_2m_beyond", 24'h0, {23'h0, seen_ok_2m});
    $display("test 2M variant done");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      end_of_test();
    end
  end

  initial begin
    repeat (3) @(posedge clk_sys_in);
    #1 nrst_in = 1'b1;
    t_sfdp();
    t_prog();
    t_erase();
    t_sreg();
    t_2m();
    end_of_test();
  end
endmodule // fam_map_test
